// ### ssbi_pkg.sv
// Shared constants and state types for the synchronous burst memory block.
// Assumes a single clock domain and plain package-qualified use everywhere.
`default_nettype none
package ssbi_pkg;
    localparam int ADDR_W = 18;
    localparam int DATA_W = 72;
    localparam int LANES  = 8;
    localparam int LANE_W = 9;
    localparam int CNT_W  = 2;

    ////////////////////////////////////////////////////////////////////////////////
    // Register map, byte addresses on the AHB-Lite slave
    localparam logic [7:0]  CTRL_OFF        = 8'h00;
    localparam logic [7:0]  STATUS_OFF      = 8'h04;
    localparam int          CTRL_SLEEP_BIT  = 0;
    localparam int          STAT_ASLEEP_BIT = 0;
    localparam int          STAT_ACTIVE_BIT = 1;
    localparam int          STAT_TWOCYC_BIT = 2;
    localparam int          STAT_CNT_LSB    = 4;
    localparam logic        CTRL_SLEEP_RST  = 1'b0;
    localparam logic [31:0] RDATA_RST       = 32'h0000_0000;
    localparam logic [7:0]  ALL_LANES       = 8'hff;
    localparam logic [7:0]  NO_LANES        = 8'h00;
    localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;

    typedef enum logic {BURST_IDLE, BURST_RUN} ssbi_burst_e;

    typedef struct packed {
        ssbi_burst_e               burst;
        logic [ADDR_W-1:0]         base;
        logic [CNT_W-1:0]          cnt;
        logic                      s1_rd;
        logic                      s1_wr;
        logic                      s1_desel;
        logic [ADDR_W-1:0]         s1_addr;
        logic [DATA_W-1:0]         wdata;
        logic [LANES-1:0]          wlanes;
        logic                      drive;
        logic                      soft_sleep;
        logic                      ph_wr;
        logic [7:0]                ph_addr;
        logic [31:0]               hrdata;
        logic                      hready;
    } ssbi_state_s;
endpackage
`default_nettype wire

// ### ssbi_mem.sv
// Storage array with lane writes and a registered read port.
// Assumes one access per cycle: read and write are never both requested.
`timescale 1ns/1ps
`default_nettype none
module ssbi_mem #(
    parameter int ADDR_W = 18,
    parameter int DATA_W = 72,
    parameter int LANES  = 8
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              rd_en,
    input  wire logic              wr_en,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic [LANES-1:0]  lanes,
    output logic      [DATA_W-1:0] rdata
);
    localparam int LW = DATA_W / LANES;

    typedef struct packed {
        logic [DATA_W-1:0] rdata;
    } ssbi_mem_state_s;

    logic [DATA_W-1:0] array [0:(1<<ADDR_W)-1];
    ssbi_mem_state_s   s_r;
    ssbi_mem_state_s   s_nxt;

    ////////////////////////////////////////////////////////////////////////////////
    // No reset on the array: contents survive sleep and reset alike
    always_ff @(posedge clk) begin
        if (wr_en) begin
            for (int l = 0; l < LANES; l++) begin
                if (lanes[l]) begin
                    array[addr][l*LW +: LW] <= wdata[l*LW +: LW];
                end
            end
        end
    end

    always_comb begin
        s_nxt = s_r;
        if (rd_en) begin
            s_nxt.rdata = array[addr];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rdata = s_r.rdata;
endmodule
`default_nettype wire

// ### ssbi_top.sv
// Synchronous pipelined burst memory, device side, with an AHB-Lite status port.
// Assumes the memory pins are synchronous to hclk; hclk is the memory clock.
//
// Implementation choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module ssbi_top (
    input  wire logic                          hclk,
    input  wire logic                          hresetn,
    input  wire logic                          hsel,
    input  wire logic [31:0]                   haddr,
    input  wire logic [1:0]                    htrans,
    input  wire logic                          hwrite,
    input  wire logic [2:0]                    hsize,
    input  wire logic [31:0]                   hwdata,
    input  wire logic                          hready,
    output logic                               hreadyout,
    output logic                               hresp,
    output logic      [31:0]                   hrdata,
    input  wire logic [ssbi_pkg::ADDR_W-1:0]   addr,
    input  wire logic [ssbi_pkg::DATA_W-1:0]   dq_i,
    output logic      [ssbi_pkg::DATA_W-1:0]   dq_o,
    output logic                               dq_oe,
    input  wire logic                          chip_select_n,
    input  wire logic                          processor_addr_strobe_n,
    input  wire logic                          controller_addr_strobe_n,
    input  wire logic                          burst_advance_n,
    input  wire logic [ssbi_pkg::LANES-1:0]    lane_write_strobe_n,
    input  wire logic                          byte_write_qualifier_n,
    input  wire logic                          all_bytes_write_n,
    input  wire logic                          output_enable_n,
    input  wire logic                          sleep_request,
    input  wire logic                          linear_order_select_n,
    input  wire logic                          deselect_latency_select
);
    ////////////////////////////////////////////////////////////////////////////////
    // Decoding helpers
    function automatic logic [ssbi_pkg::LANES-1:0] lane_mask(
        input logic                       gw_n,
        input logic                       bw_n,
        input logic [ssbi_pkg::LANES-1:0] strobe_n
    );
        if (!gw_n) begin
            lane_mask = ssbi_pkg::ALL_LANES;
        end else if (!bw_n) begin
            lane_mask = ~strobe_n;
        end else begin
            lane_mask = ssbi_pkg::NO_LANES;
        end
    endfunction

    function automatic logic [1:0] burst_lsb(
        input logic [1:0] start,
        input logic [1:0] cnt,
        input logic       lin_n
    );
        if (lin_n) begin
            burst_lsb = start ^ cnt;
        end else begin
            burst_lsb = 2'(start + cnt);
        end
    endfunction

    function automatic logic [31:0] reg_read(
        input logic [7:0]           off,
        input ssbi_pkg::ssbi_state_s st,
        input logic                 asleep_now,
        input logic                 two_cyc
    );
        reg_read = ssbi_pkg::RDATA_RST;
        case (off)
            ssbi_pkg::CTRL_OFF: begin
                reg_read[ssbi_pkg::CTRL_SLEEP_BIT] = st.soft_sleep;
            end
            ssbi_pkg::STATUS_OFF: begin
                reg_read[ssbi_pkg::STAT_ASLEEP_BIT] = asleep_now;
                reg_read[ssbi_pkg::STAT_ACTIVE_BIT] = (st.burst == ssbi_pkg::BURST_RUN);
                reg_read[ssbi_pkg::STAT_TWOCYC_BIT] = two_cyc;
                reg_read[ssbi_pkg::STAT_CNT_LSB +: 2] = st.cnt;
            end
            default: begin
                reg_read = ssbi_pkg::RDATA_RST;
            end
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Input decode
    ssbi_pkg::ssbi_state_s s_r;
    ssbi_pkg::ssbi_state_s s_nxt;
    logic                  asleep;
    logic                  two_cycle_deselect;
    logic                  start;
    logic                  load;
    logic                  cont;
    logic                  desel_in;
    logic                  wr_req;
    logic                  ahb_take;

    // Sleep blocks command capture at once; a stopped clock sleeps by itself
    assign asleep             = sleep_request | s_r.soft_sleep;
    assign two_cycle_deselect = ~deselect_latency_select;
    assign start    = ~processor_addr_strobe_n | ~controller_addr_strobe_n;
    assign load     = ~asleep & start & ~chip_select_n;
    assign desel_in = ~asleep & start & chip_select_n;
    assign cont     = ~asleep & ~start & (s_r.burst == ssbi_pkg::BURST_RUN);
    // A processor strobe start is always a read
    assign wr_req   = (~all_bytes_write_n | ~byte_write_qualifier_n)
                      & ~(load & ~processor_addr_strobe_n);
    assign ahb_take = hsel & hready & (htrans == ssbi_pkg::HTRANS_NONSEQ
                                       || htrans == 2'h3);

    ////////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        s_nxt          = s_r;
        s_nxt.s1_rd    = (load | cont) & ~wr_req;
        s_nxt.s1_wr    = (load | cont) & wr_req;
        s_nxt.s1_desel = desel_in;
        s_nxt.wdata    = dq_i;
        s_nxt.wlanes   = lane_mask(all_bytes_write_n, byte_write_qualifier_n,
                                   lane_write_strobe_n);
        if (load) begin
            s_nxt.burst   = ssbi_pkg::BURST_RUN;
            s_nxt.base    = addr;
            s_nxt.cnt     = '0;
            s_nxt.s1_addr = addr;
        end else if (cont) begin
            if (!burst_advance_n) begin
                s_nxt.cnt = 2'(s_r.cnt + 2'h1);
            end
            s_nxt.s1_addr = {s_r.base[ssbi_pkg::ADDR_W-1:2],
                             burst_lsb(s_r.base[1:0], s_nxt.cnt, linear_order_select_n)};
        end else if (desel_in) begin
            s_nxt.burst = ssbi_pkg::BURST_IDLE;
        end
        // Dual-cycle follows the read pipe; single-cycle cuts one stage early
        if (two_cycle_deselect) begin
            s_nxt.drive = s_r.s1_rd;
        end else begin
            s_nxt.drive = s_r.s1_rd & ~desel_in;
        end
        // AHB-Lite slave, zero wait states, always OKAY
        s_nxt.hready = 1'b1;
        s_nxt.ph_wr  = ahb_take & hwrite;
        s_nxt.ph_addr = haddr[7:0];
        if (ahb_take && !hwrite) begin
            s_nxt.hrdata = reg_read(haddr[7:0], s_r, asleep, two_cycle_deselect);
        end
        if (s_r.ph_wr && s_r.ph_addr == ssbi_pkg::CTRL_OFF) begin
            s_nxt.soft_sleep = hwdata[ssbi_pkg::CTRL_SLEEP_BIT];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r            <= '0;
            s_r.burst      <= ssbi_pkg::BURST_IDLE;
            s_r.soft_sleep <= ssbi_pkg::CTRL_SLEEP_RST;
            s_r.hrdata     <= ssbi_pkg::RDATA_RST;
            s_r.hready     <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Array and outputs
    ssbi_mem #(
        .ADDR_W (ssbi_pkg::ADDR_W),
        .DATA_W (ssbi_pkg::DATA_W),
        .LANES  (ssbi_pkg::LANES)
    ) u_mem (
        .clk    (hclk),
        .rst_n  (hresetn),
        .rd_en  (s_r.s1_rd),
        .wr_en  (s_r.s1_wr),
        .addr   (s_r.s1_addr),
        .wdata  (s_r.wdata),
        .lanes  (s_r.wlanes),
        .rdata  (dq_o)
    );

    // Output enable and sleep_request gate the pins without a clock edge; soft sleep does not
    assign dq_oe     = s_r.drive & ~output_enable_n & ~sleep_request;
    assign hreadyout = s_r.hready;
    assign hresp     = 1'b0;
    assign hrdata    = s_r.hrdata;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_burst_load: assert property (load |=> s_r.burst == ssbi_pkg::BURST_RUN
        && s_r.cnt == 2'h0 && s_r.s1_addr == $past(addr))
        else $error("burst start did not load the address");
    a_burst_step: assert property (cont && !burst_advance_n |=>
        s_r.cnt == 2'($past(s_r.cnt) + 2'h1))
        else $error("burst counter did not step on advance");
    a_burst_hold: assert property (cont && burst_advance_n |=> $stable(s_r.cnt))
        else $error("burst counter moved without advance");
    a_lin_order: assert property (cont && !linear_order_select_n |=>
        s_r.s1_addr[1:0] == 2'(s_r.base[1:0] + s_r.cnt))
        else $error("linear order address wrong");
    a_scd_off: assert property (!two_cycle_deselect && desel_in |=> !s_r.drive)
        else $error("single-cycle deselect did not cut output");
    a_dcd_hold: assert property (two_cycle_deselect && desel_in && s_r.s1_rd
        && !$past(desel_in) |=> s_r.drive ##1 !s_r.drive)
        else $error("dual-cycle deselect timing wrong");
    a_read_lat: assert property (two_cycle_deselect && load && !wr_req
        |=> s_r.s1_rd ##1 s_r.drive)
        else $error("read did not reach the output stage");
    a_gw_lanes: assert property ((load || cont) && !all_bytes_write_n
        && processor_addr_strobe_n
        |=> s_r.s1_wr && s_r.wlanes == ssbi_pkg::ALL_LANES)
        else $error("all-bytes write missed lanes");
    a_intl_order: assert property (cont && linear_order_select_n |=>
        s_r.s1_addr[1:0] == (s_r.base[1:0] ^ s_r.cnt))
        else $error("interleaved order address wrong");
    a_write_load: assert property (load && !all_bytes_write_n && processor_addr_strobe_n
        |=> s_r.s1_wr && s_r.s1_addr == $past(addr))
        else $error("write command not registered");
    a_bw_lanes: assert property ((load || cont) && all_bytes_write_n
        && !byte_write_qualifier_n && processor_addr_strobe_n
        |=> s_r.wlanes == ~$past(lane_write_strobe_n))
        else $error("byte write lanes wrong");
    a_sleep_idle: assert property (sleep_request |=> !s_r.s1_rd && !s_r.s1_wr)
        else $error("access accepted while asleep");
    a_pins_off: assert property (output_enable_n || !s_r.drive |-> !dq_oe)
        else $error("data pins driven without a read");

    c_burst4: cover property (load ##1 (cont && !burst_advance_n) [*3]);
    c_write:  cover property (s_r.s1_wr && s_r.wlanes != ssbi_pkg::ALL_LANES);
    c_scd:    cover property (!two_cycle_deselect && s_r.drive && desel_in);
    c_sleep:  cover property (sleep_request && s_r.burst == ssbi_pkg::BURST_RUN);
endmodule
`default_nettype wire

// ### ssbi_host_model.sv
// Host-side model of a memory controller driving the synchronous memory pins.
// Assumes one caller; each command is set right after a rising edge, taken at the next.
`timescale 1ns/1ps
`default_nettype none
module ssbi_host_model (
    input  wire logic                    hclk,
    output logic [ssbi_pkg::ADDR_W-1:0]  addr,
    output logic [ssbi_pkg::DATA_W-1:0]  dq_i,
    output logic                         chip_select_n,
    output logic                         processor_addr_strobe_n,
    output logic                         controller_addr_strobe_n,
    output logic                         burst_advance_n,
    output logic [ssbi_pkg::LANES-1:0]   lane_write_strobe_n,
    output logic                         byte_write_qualifier_n,
    output logic                         all_bytes_write_n
);
    initial begin
        addr = '0;
        dq_i = '0;
        {chip_select_n, processor_addr_strobe_n, controller_addr_strobe_n} = 3'h7;
        {burst_advance_n, all_bytes_write_n, byte_write_qualifier_n} = 3'h7;
        lane_write_strobe_n = 8'hff;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Kinds: 0 idle, 1 read load, 2 write load, 3 advance, 4 hold, 5 deselect
    task automatic drive(input int kind, input logic [17:0] a, input logic [71:0] d,
                         input logic [9:0] w);
        @(posedge hclk);
        processor_addr_strobe_n  <= (kind != 1);
        controller_addr_strobe_n <= !(kind == 2 || kind == 5);
        chip_select_n            <= !(kind == 1 || kind == 2);
        burst_advance_n          <= (kind != 3);
        addr                     <= a;
        {all_bytes_write_n, byte_write_qualifier_n, lane_write_strobe_n} <=
            (kind == 2) ? w : 10'h3ff;
        // Released data lines flip every cycle so a stale capture shows
        dq_i                     <= (kind == 2) ? d : ~dq_i;
    endtask
    task automatic cmd_read(input logic [17:0] a);  drive(1, a, '0, '0);  endtask
    task automatic cmd_write(input logic [17:0] a, input logic [71:0] d, input logic [9:0] w);
        drive(2, a, d, w);
    endtask
    task automatic cmd_adv();   drive(3, '0, '0, '0);  endtask
    task automatic cmd_hold();  drive(4, '0, '0, '0);  endtask
    task automatic cmd_desel(); drive(5, '0, '0, '0);  endtask
    task automatic cmd_idle();  drive(0, '0, '0, '0);  endtask
endmodule
`default_nettype wire

// ### ssbi_top_tb.sv
// Self-checking bench for the burst memory block: memory pins and status port.
// Assumes the host model drives the command, address and data pins and this bench is the AHB-Lite master.
`timescale 1ns/1ps
`default_nettype none
module ssbi_top_tb;
    typedef struct packed {logic [9:0] wctl; logic [7:0] mask;} ssbi_row_s;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, rdv;
    logic [1:0]  htrans = '0, lsb;
    logic        output_enable_n = 1'b0, sleep_request = 1'b0;
    logic        linear_order_select_n = 1'b0, deselect_latency_select = 1'b0;
    logic [71:0] d, m, old = '0;
    int          n_errors = 0, compares = 0, cycles = 0, c;
    wire         hreadyout, hresp, dq_oe, cs_n, ps_n, cs_strobe_n, adv_n, bw_n, gw_n;
    wire [31:0]  hrdata;
    wire [17:0]  addr;
    wire [71:0]  dq_i, dq_o;
    wire [7:0]   lanes_n;
    // Qualifier alone with strobes high, and strobes without qualifier, are the traps
    ssbi_row_s rows [6] = '{'{10'h1ff, 8'hff}, '{10'h2fe, 8'h01}, '{10'h00f, 8'hff},
                            '{10'h2ff, 8'h00}, '{10'h25a, 8'ha5}, '{10'h300, 8'h00}};

    always #12.5 hclk = ~hclk;
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 2000) begin
            n_errors++;
            print_verdict();
        end
    end

    ssbi_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .addr(addr), .dq_i(dq_i),
        .dq_o(dq_o), .dq_oe(dq_oe), .chip_select_n(cs_n), .processor_addr_strobe_n(ps_n),
        .controller_addr_strobe_n(cs_strobe_n), .burst_advance_n(adv_n),
        .lane_write_strobe_n(lanes_n), .byte_write_qualifier_n(bw_n),
        .all_bytes_write_n(gw_n), .output_enable_n(output_enable_n),
        .sleep_request(sleep_request), .linear_order_select_n(linear_order_select_n),
        .deselect_latency_select(deselect_latency_select));
    ssbi_host_model i_host (.hclk(hclk), .addr(addr), .dq_i(dq_i), .chip_select_n(cs_n),
        .processor_addr_strobe_n(ps_n), .controller_addr_strobe_n(cs_strobe_n),
        .burst_advance_n(adv_n), .lane_write_strobe_n(lanes_n),
        .byte_write_qualifier_n(bw_n), .all_bytes_write_n(gw_n));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        if (n_errors == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [71:0] got, input logic [71:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkb(input logic got, input logic exp);
        chk({71'h0, got}, {71'h0, exp});
    endtask
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= ssbi_pkg::HTRANS_NONSEQ;
        haddr  <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= w ? wd : 32'h0;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [17:0] a, input logic [71:0] dv, input logic [9:0] w);
        i_host.cmd_write(a, dv, w);
        i_host.cmd_idle();
    endtask
    task automatic rd(input logic [17:0] a, input logic [71:0] exp);
        // Idle cycles would continue the burst and keep the pins driven
        i_host.cmd_read(a);
        i_host.cmd_desel();
        i_host.cmd_idle();
        @(negedge hclk);
        chk(dq_o, exp);
        chkb(dq_oe, 1'b1);
        i_host.cmd_idle();
        @(negedge hclk);
        chkb(dq_oe, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        @(negedge hclk);
        chkb(hreadyout, 1'b1);
        chkb(hresp, 1'b0);
        chkb(dq_oe, 1'b0);
        chk(72'(hrdata), 72'h0);
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        for (int r = 0; r < 6; r++) begin
            d = {8{9'(r * 73 + 5)}};
            for (int k = 0; k < 8; k++) m[9*k +: 9] = {9{rows[r].mask[k]}};
            wr(18'h3_fff5, d, rows[r].wctl);
            old = (old & ~m) | (d & m);
            rd(18'h3_fff5, old);
        end
        for (int i = 0; i < 4; i++) wr(18'h0_0010 + 18'(i), 72'(i + 1), 10'h1ff);
        for (int md = 0; md < 2; md++) begin
            linear_order_select_n <= md[0];
            i_host.cmd_read(18'h0_0011);
            i_host.cmd_adv();
            for (int s = 0; s < 5; s++) begin
                if (s < 2) i_host.cmd_adv();
                else if (s == 2) i_host.cmd_hold();
                else i_host.cmd_idle();
                @(negedge hclk);
                c = (s < 4) ? s : 3;
                lsb = md[0] ? (2'(1) ^ 2'(c)) : 2'(1 + c);
                chk(dq_o, 72'(lsb + 1));
            end
        end
        for (int j = 0; j < 5; j++) begin
            if (j < 3) i_host.cmd_read(18'h0_0013 - 18'(j));
            else i_host.cmd_idle();
            if (j >= 2) begin
                @(negedge hclk);
                chk(dq_o, 72'(6 - j));
            end
        end
        i_host.cmd_read(18'h0_0010);
        i_host.cmd_hold();
        i_host.cmd_hold();
        @(negedge hclk);
        // Mid-cycle changes: the output gate must not wait for an edge
        output_enable_n = 1'b1;
        #2 chkb(dq_oe, 1'b0);
        output_enable_n = 1'b0;
        #2 chkb(dq_oe, 1'b1);
        sleep_request = 1'b1;
        #2 chkb(dq_oe, 1'b0);
        sleep_request = 1'b0;
        #2 chkb(dq_oe, 1'b1);
        i_host.cmd_idle();
        for (int sel = 0; sel < 2; sel++) begin
            deselect_latency_select <= sel[0];
            i_host.cmd_idle();
            i_host.cmd_read(18'h0_0010);
            i_host.cmd_desel();
            i_host.cmd_idle();
            @(negedge hclk);
            chkb(dq_oe, !sel[0]);
            i_host.cmd_idle();
            @(negedge hclk);
            chkb(dq_oe, 1'b0);
        end
        ahb(1'b1, {24'h0, ssbi_pkg::CTRL_OFF}, 32'h0000_0001, rdv);
        ahb(1'b0, {24'h0, ssbi_pkg::STATUS_OFF}, 32'h0, rdv);
        chkb(rdv[ssbi_pkg::STAT_ASLEEP_BIT], 1'b1);
        chkb(rdv[ssbi_pkg::STAT_TWOCYC_BIT], 1'b0);
        chkb(rdv[ssbi_pkg::STAT_ACTIVE_BIT], 1'b0);
        deselect_latency_select <= 1'b0;
        wr(18'h0_0010, {72{1'b1}}, 10'h1ff);
        ahb(1'b1, {24'h0, ssbi_pkg::CTRL_OFF}, 32'h0, rdv);
        ahb(1'b0, 32'h0000_0010, 32'h0, rdv);
        chk(72'(rdv), 72'h0);
        rd(18'h0_0010, 72'h1);
        print_verdict();
    end
endmodule
`default_nettype wire
